// *** core/sep_core.sv ***
// serial eeprom command decoder, status register and write guard
`timescale 1ns/1ps
`default_nettype none
// Operation
// - sample serial input on clock rise
// - drive serial output on clock fall
// - output high impedance while deselected
// - low guard pin plus enable blocks status
// - pause input freezes shifting, resumes later
// - first byte is opcode, unknown ignored
// - latch set and latch clear opcodes
// - status read and status write opcodes
// - memory read and memory write opcodes
// - status bit layout, bits 6..4 zero
// - busy flag high during write cycle
// - latch set and cleared by opcodes
// - guard bits via status write only
// - setting 01 guards top quarter
// - setting 10 guards upper half
// - setting 11 guards whole array
// - latch low refuses every write
// - busy: only status read accepted
// - status write changes bits 7,3,2
// - latch clear at reset and after write
module sep_core import sep_pkg::*; #(
    parameter int ARRAY_AW = ARRAY_AW_DEF,
    parameter int WC_CYC   = WRITE_CYCLE_CYC
) (
    input  wire logic                i_clock,
    input  wire logic                i_rst_n,
    input  wire logic                i_cs_n,
    input  wire logic                i_sck,
    input  wire logic                i_si,
    input  wire logic                i_hold_n,
    input  wire logic                i_guard_n,
    output logic                     o_so,
    output logic                     o_so_oe,
    output logic [ARRAY_AW-1:0]      o_mem_raddr,
    input  wire logic [7:0]          i_mem_rdata,
    output logic                     o_wr_valid,
    input  wire logic                i_wr_ready,
    output logic [ARRAY_AW-1:0]      o_wr_addr,
    output logic [7:0]               o_wr_data,
    output logic                     o_busy,
    output logic [7:0]               o_status
);
    localparam int CW = $clog2(WC_CYC + 1);
    localparam logic [CW-1:0] WC_LAST = CW'(WC_CYC - 1);

    logic [4:0]           pin_s;
    logic                 cs_n_s, sck_s, si_s, hold_n_s, guard_n_s;
    logic                 sck_q, cs_n_q;
    logic                 live, sck_rise, sck_fall, cs_fall, cs_rise;
    sep_state_t           state_q;
    logic [2:0]           bit_q;
    logic                 abyte_q;
    logic [7:0]           shreg_q, opc_q, rx_byte, sr_new_q, tx_q, tx_src;
    logic [ADDR_BITS-1:0] addr_q;
    logic                 byte_end, so_q, tx_on_q;
    logic                 wel_q, busy_q, pin_guard_q, wrote_q;
    logic [1:0]           bg_q;
    logic [CW-1:0]        cnt_q;
    logic [7:0]           status_w;
    logic                 sr_open, commit_sr, commit_mem, write_start;
    logic                 latch_set, latch_clr, busy_done;
    logic                 push_v, buf_ready;

    // true when the addressed byte lies in a guarded block
    function automatic logic is_guarded(input logic [1:0] bg, input logic [ARRAY_AW-1:0] a);
        case (bg)
            2'b01:   return &a[ARRAY_AW-1:ARRAY_AW-2];
            2'b10:   return a[ARRAY_AW-1];
            2'b11:   return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : is_guarded

    // pins pass two flops before use
    sep_sync #(
        .W   (5),
        .RST (5'h13)
    ) u_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_d     ({i_cs_n, i_sck, i_si, i_hold_n, i_guard_n}),
        .o_q     (pin_s)
    );
    assign {cs_n_s, sck_s, si_s, hold_n_s, guard_n_s} = pin_s;

    // previous levels for edge finding
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            sck_q  <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            sck_q  <= sck_s;
            cs_n_q <= cs_n_s;
        end
    end

    // clock edges count only while selected and not paused
    assign live     = !cs_n_s && hold_n_s;
    assign sck_rise = live && sck_s && !sck_q;
    assign sck_fall = live && !sck_s && sck_q;
    assign cs_fall  = !cs_n_s && cs_n_q;
    assign cs_rise  = cs_n_s && !cs_n_q;
    assign rx_byte  = {shreg_q[6:0], si_s};
    assign byte_end = sck_rise && (bit_q == 3'h7);

    // command sequencer, bits taken on clock rise
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
            bit_q   <= 3'h0;
            abyte_q <= 1'b0;
            shreg_q <= 8'h00;
            opc_q   <= 8'h00;
            addr_q  <= '0;
        end else if (cs_fall) begin
            state_q <= ST_OPC;
            bit_q   <= 3'h0;
            abyte_q <= 1'b0;
        end else if (cs_rise) begin
            state_q <= ST_IDLE;
        end else if (sck_rise) begin
            shreg_q <= rx_byte;
            bit_q   <= bit_q + 3'h1;
            case (state_q)
                ST_OPC: begin
                    if (bit_q == 3'h7) begin
                        opc_q <= rx_byte;
                        if (busy_q && rx_byte != OPC_STATUS_READ) begin
                            state_q <= ST_IGNORE;
                        end else begin
                            case (rx_byte)
                                OPC_LATCH_SET:    state_q <= ST_DONE;
                                OPC_LATCH_CLEAR:  state_q <= ST_DONE;
                                OPC_STATUS_READ:  state_q <= ST_SR_OUT;
                                OPC_STATUS_WRITE: state_q <= ST_SR_IN;
                                OPC_MEM_READ:     state_q <= ST_ADDR;
                                OPC_MEM_WRITE:    state_q <= ST_ADDR;
                                default:          state_q <= ST_IGNORE;
                            endcase
                        end
                    end
                end
                ST_ADDR: begin
                    addr_q <= {addr_q[ADDR_BITS-2:0], si_s};
                    if (bit_q == 3'h7) begin
                        abyte_q <= 1'b1;
                        if (abyte_q) begin
                            state_q <= (opc_q == OPC_MEM_READ) ? ST_DATA_OUT : ST_DATA_IN;
                        end
                    end
                end
                ST_DATA_IN: begin
                    // page roll-over on the low address bits
                    if (bit_q == 3'h7) begin
                        addr_q[PAGE_BITS-1:0] <= addr_q[PAGE_BITS-1:0] + PAGE_BITS'(1);
                    end
                end
                ST_DATA_OUT: begin
                    if (bit_q == 3'h7) begin
                        addr_q <= addr_q + ADDR_BITS'(1);
                    end
                end
                ST_SR_IN: begin
                    if (bit_q == 3'h7) begin
                        state_q <= ST_DONE;
                    end
                end
                default: ;
            endcase
        end
    end

    // status byte captured for a status write
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            sr_new_q <= 8'h00;
        end else if (state_q == ST_SR_IN && byte_end) begin
            sr_new_q <= rx_byte;
        end
    end

    // status image, reserved bits zero
    always_comb begin
        status_w               = 8'h00;
        status_w[SR_PIN_GUARD] = pin_guard_q;
        status_w[SR_BG_HI]     = bg_q[1];
        status_w[SR_BG_LO]     = bg_q[0];
        status_w[SR_WEL]       = wel_q;
        status_w[SR_BUSY]      = busy_q;
    end

    // commit conditions, checked when select rises; latch clear at the end of its opcode byte
    assign sr_open    = wel_q && !(pin_guard_q && !guard_n_s);
    assign commit_sr  = cs_rise && state_q == ST_DONE && opc_q == OPC_STATUS_WRITE
                        && bit_q == 3'h0 && sr_open;
    assign commit_mem = cs_rise && state_q == ST_DATA_IN && bit_q == 3'h0 && wrote_q;
    assign write_start = commit_sr || commit_mem;
    assign latch_set  = cs_rise && state_q == ST_DONE && opc_q == OPC_LATCH_SET
                        && bit_q == 3'h0;
    assign latch_clr  = state_q == ST_OPC && byte_end && !busy_q
                        && rx_byte == OPC_LATCH_CLEAR;
    assign busy_done  = busy_q && cnt_q == WC_LAST && !o_wr_valid;

    // guard and pin-guard bits, only via status write
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            pin_guard_q <= SR_RESET[SR_PIN_GUARD];
            bg_q        <= {SR_RESET[SR_BG_HI], SR_RESET[SR_BG_LO]};
        end else if (commit_sr) begin
            pin_guard_q <= sr_new_q[SR_PIN_GUARD];
            bg_q        <= {sr_new_q[SR_BG_HI], sr_new_q[SR_BG_LO]};
        end
    end

    // write enable latch
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            wel_q <= SR_RESET[SR_WEL];
        end else if (latch_set) begin
            wel_q <= 1'b1;
        end else if (latch_clr || busy_done) begin
            wel_q <= 1'b0;
        end
    end

    // self-timed write cycle
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            busy_q <= SR_RESET[SR_BUSY];
            cnt_q  <= '0;
        end else if (write_start) begin
            busy_q <= 1'b1;
            cnt_q  <= '0;
        end else if (busy_done) begin
            busy_q <= 1'b0;
        end else if (busy_q && cnt_q != WC_LAST) begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    // data bytes go out only when enabled and unguarded
    assign push_v = state_q == ST_DATA_IN && byte_end && wel_q && !busy_q
                    && !is_guarded(bg_q, addr_q[ARRAY_AW-1:0]);

    // remembers that this frame loaded at least one byte
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || cs_fall) begin
            wrote_q <= 1'b0;
        end else if (push_v && buf_ready) begin
            wrote_q <= 1'b1;
        end
    end

    sep_buf #(
        .W     (ARRAY_AW + 8),
        .DEPTH (2)
    ) u_buf (
        .i_clock     (i_clock),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (push_v),
        .o_in_ready  (buf_ready),
        .i_in_data   ({addr_q[ARRAY_AW-1:0], rx_byte}),
        .o_out_valid (o_wr_valid),
        .i_out_ready (i_wr_ready),
        .o_out_data  ({o_wr_addr, o_wr_data})
    );

    // transmit shifter, bits driven on clock fall
    assign tx_src = (state_q == ST_SR_OUT) ? status_w : i_mem_rdata;
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || cs_fall) begin
            so_q    <= 1'b0;
            tx_q    <= 8'h00;
            tx_on_q <= 1'b0;
        end else if (sck_fall && (state_q == ST_SR_OUT || state_q == ST_DATA_OUT)) begin
            tx_on_q <= 1'b1;
            if (bit_q == 3'h0) begin
                so_q <= tx_src[7];
                tx_q <= {tx_src[6:0], 1'b0};
            end else begin
                so_q <= tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    assign o_so        = so_q;
    assign o_so_oe     = tx_on_q && live;
    assign o_mem_raddr = addr_q[ARRAY_AW-1:0];
    assign o_busy      = busy_q;
    assign o_status    = status_w;

    // checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    sequence s_opc_done;
        state_q == ST_OPC && byte_end;
    endsequence

    a_so_off_idle: assert property (cs_n_s |-> !o_so_oe)
        else $error("serial output enabled while deselected");
    a_so_on_fall: assert property ($changed(o_so) |-> $past(sck_fall || cs_fall))
        else $error("serial output changed away from a clock fall");
    a_in_on_rise: assert property (sck_rise |=> shreg_q[0] == $past(si_s))
        else $error("input bit not taken on clock rise");
    a_opc_unknown: assert property (s_opc_done ##0 (!busy_q && rx_byte > OPC_LATCH_SET)
        |=> state_q == ST_IGNORE)
        else $error("undefined opcode not ignored");
    a_busy_filter: assert property (s_opc_done ##0 (busy_q && rx_byte != OPC_STATUS_READ)
        |=> state_q == ST_IGNORE)
        else $error("command accepted during write cycle");
    a_latch_set: assert property (latch_set |=> wel_q)
        else $error("latch not set");
    a_latch_clear: assert property (s_opc_done ##0 (!busy_q && rx_byte == OPC_LATCH_CLEAR)
        |=> !wel_q)
        else $error("latch not cleared");
    a_pin_guard: assert property (cs_rise && pin_guard_q && !guard_n_s && opc_q == OPC_STATUS_WRITE
        |=> $stable(bg_q) && !$rose(busy_q))
        else $error("status write passed the guard pin");
    a_busy_len: assert property ($rose(busy_q) |-> busy_q [*8])
        else $error("write cycle ended too early");
    a_guard_push: assert property (push_v |-> wel_q
        && !is_guarded(bg_q, addr_q[ARRAY_AW-1:0]))
        else $error("write to guarded address");
    a_hold_freeze: assert property (!hold_n_s && !cs_n_s |=> $stable(bit_q))
        else $error("shifting while paused");
    a_sr_zeros: assert property (commit_sr |=> status_w[6:4] == 3'h0 && busy_q)
        else $error("status write disturbed fixed bits");
endmodule : sep_core
`default_nettype wire

// *** core/sep_pkg.sv ***
// shared constants and types of the serial eeprom command front end
`default_nettype none
package sep_pkg;
    // instruction opcodes
    localparam logic [7:0] OPC_LATCH_SET    = 8'h06;
    localparam logic [7:0] OPC_LATCH_CLEAR  = 8'h04;
    localparam logic [7:0] OPC_STATUS_READ  = 8'h05;
    localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OPC_MEM_READ     = 8'h03;
    localparam logic [7:0] OPC_MEM_WRITE    = 8'h02;
    // status register field positions
    localparam int SR_PIN_GUARD = 7;
    localparam int SR_BG_HI     = 3;
    localparam int SR_BG_LO     = 2;
    localparam int SR_WEL       = 1;
    localparam int SR_BUSY      = 0;
    // status register reset value
    localparam logic [7:0] SR_RESET = 8'h00;
    // array geometry
    localparam int ARRAY_AW_DEF = 10;
    localparam int PAGE_BITS    = 5;
    localparam int ADDR_BITS    = 16;
    // timing: clock rate and self-timed write cycle
    localparam int CLK_MHZ        = 200;
    localparam int WRITE_CYCLE_MS = 5;
    localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * 1000 * CLK_MHZ;
    // host-side wait after supply is stable
    localparam int POWERUP_READ_DELAY_MS  = 1;
    localparam int POWERUP_WRITE_DELAY_MS = 1;
    // command sequencer states
    typedef enum logic [3:0] {
        ST_IDLE, ST_OPC, ST_ADDR, ST_DATA_IN, ST_DATA_OUT,
        ST_SR_IN, ST_SR_OUT, ST_DONE, ST_IGNORE
    } sep_state_t;
endpackage : sep_pkg
`default_nettype wire

// *** core/sep_sync.sv ***
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module sep_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         i_clock,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage feeds only the second
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            meta_q <= RST;
            sync_q <= RST;
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end

    assign o_q = sync_q;
endmodule : sep_sync
`default_nettype wire

// *** core/sep_buf.sv ***
// small valid/ready buffer, default two entries
`timescale 1ns/1ps
`default_nettype none
module sep_buf #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    input  wire logic         i_clock,
    input  wire logic         i_rst_n,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic      [W-1:0] o_out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

    logic [W-1:0]  mem_q [DEPTH];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [PW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign o_in_ready  = (cnt_q != FULL);
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data  = mem_q[rp_q];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    // storage
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem_q[wp_q] <= i_in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + PW'(1);
            if (pop) rp_q <= rp_q + PW'(1);
            if (push && !pop) cnt_q <= cnt_q + (PW+1)'(1);
            else if (pop && !push) cnt_q <= cnt_q - (PW+1)'(1);
        end
    end
endmodule : sep_buf
`default_nettype wire

// *** tb/sep_host.sv ***
// host spi controller model: select, serial clock, serial data and pause
`timescale 1ns/1ps
`default_nettype none
module sep_host (
    input  wire logic i_clock,
    input  wire logic i_so,
    input  wire logic i_so_oe,
    output logic      o_cs_n,
    output logic      o_sck,
    output logic      o_si,
    output logic      o_hold_n
);
    logic idle_q;  // clock idle level of the frame, mode (1,1) when high
    // quiet bus at time zero
    initial begin
        o_cs_n   = 1'b1;
        o_sck    = 1'b0;
        o_si     = 1'b0;
        o_hold_n = 1'b1;
        idle_q   = 1'b0;
    end
    // open a frame with the clock parked at its idle level
    task automatic start(input logic m);
        @(posedge i_clock);
        idle_q = m;
        o_sck <= m;
        repeat (6) @(posedge i_clock);
        o_cs_n <= 1'b0;
        repeat (6) @(posedge i_clock);
    endtask : start
    // one byte, msb first; data set while clock low, output read at rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic oe);
        oe = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            @(posedge i_clock);
            o_sck <= 1'b0;
            o_si  <= tx[i];
            repeat (12) @(posedge i_clock);
            o_sck <= 1'b1;
            rx[i] = i_so;
            oe    = oe & i_so_oe;
            repeat (12) @(posedge i_clock);
        end
    endtask : xfer
    // pause with the clock low at both pause edges
    task automatic pause(input int n, output logic oe);
        @(posedge i_clock);
        o_sck <= 1'b0;
        repeat (4) @(posedge i_clock);
        o_hold_n <= 1'b0;
        repeat (n) @(posedge i_clock);
        oe = i_so_oe;
        o_hold_n <= 1'b1;
        repeat (4) @(posedge i_clock);
    endtask : pause
    // close the frame; the released data line shows no stale value
    task automatic stop();
        @(posedge i_clock);
        o_sck <= idle_q;
        repeat (6) @(posedge i_clock);
        o_cs_n <= 1'b1;
        o_si   <= ~o_si;
        repeat (8) @(posedge i_clock);
    endtask : stop
endmodule : sep_host
`default_nettype wire

// *** tb/test_spi_eeprom_command_protect.sv ***
// self-checking bench of the serial eeprom command front end
`timescale 1ns/1ps
`default_nettype none
module test_spi_eeprom_command_protect import sep_pkg::*;;
    localparam int AW = 10;
    localparam int WC = 20;
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] arg;
        logic       two;
        logic       guard_n;
        logic [7:0] exp;
    } sep_row_t;
    // command, argument, guard pin and the status it should leave
    localparam sep_row_t ROWS [11] = '{
        '{OPC_LATCH_SET,    8'h00, 1'b0, 1'b1, 8'h02},
        '{OPC_LATCH_CLEAR,  8'h00, 1'b0, 1'b1, 8'h00},
        '{OPC_STATUS_WRITE, 8'h8c, 1'b1, 1'b1, 8'h00},
        '{OPC_LATCH_SET,    8'h00, 1'b0, 1'b1, 8'h02},
        '{OPC_STATUS_WRITE, 8'hff, 1'b1, 1'b1, 8'h8c},
        '{OPC_LATCH_SET,    8'h00, 1'b0, 1'b1, 8'h8e},
        '{OPC_STATUS_WRITE, 8'h00, 1'b1, 1'b0, 8'h8e},
        '{OPC_STATUS_WRITE, 8'h04, 1'b1, 1'b1, 8'h04},
        '{8'haa,            8'h06, 1'b1, 1'b1, 8'h04},
        '{OPC_LATCH_SET,    8'h00, 1'b0, 1'b1, 8'h06},
        '{OPC_LATCH_CLEAR,  8'h00, 1'b0, 1'b1, 8'h04}
    };
    logic          clock;
    logic          rst_n    = 1'b0;
    logic          guard_n  = 1'b1;
    logic          wr_ready = 1'b1;
    logic          cs_n;
    logic          sck;
    logic          si;
    logic          hold_n;
    logic          so;
    logic          so_oe;
    logic [AW-1:0] mem_raddr;
    logic [7:0]    mem_rdata;
    logic          wr_valid;
    logic [AW-1:0] wr_addr;
    logic [7:0]    wr_data;
    logic          busy;
    logic [7:0]    status;
    logic [7:0]    mem [1024];
    int            failures        = 0;
    int            samples_checked = 0;
    // 200 MHz system clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    sep_core #(.ARRAY_AW(AW), .WC_CYC(WC)) i_dut (
        .i_clock    (clock),
        .i_rst_n    (rst_n),
        .i_cs_n     (cs_n),
        .i_sck      (sck),
        .i_si       (si),
        .i_hold_n   (hold_n),
        .i_guard_n  (guard_n),
        .o_so       (so),
        .o_so_oe    (so_oe),
        .o_mem_raddr(mem_raddr),
        .i_mem_rdata(mem_rdata),
        .o_wr_valid (wr_valid),
        .i_wr_ready (wr_ready),
        .o_wr_addr  (wr_addr),
        .o_wr_data  (wr_data),
        .o_busy     (busy),
        .o_status   (status)
    );
    sep_host i_host (
        .i_clock (clock),
        .i_so    (so),
        .i_so_oe (so_oe),
        .o_cs_n  (cs_n),
        .o_sck   (sck),
        .o_si    (si),
        .o_hold_n(hold_n)
    );
    function automatic logic [7:0] init_of(input logic [9:0] a);
        return a[7:0] ^ 8'h3c;
    endfunction : init_of
    // array model: combinational read, write when a word is taken
    assign mem_rdata = mem[mem_raddr];
    initial begin
        for (int i = 0; i < 1024; i++) mem[i] = init_of(10'(i));
    end
    always @(posedge clock) begin
        if (wr_valid && wr_ready) mem[wr_addr] <= wr_data;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    // bounded wait for the write cycle to finish
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            @(posedge clock);
            n++;
        end
        check("busy end", {15'h0, busy}, 16'h0);
    endtask : wait_idle
    task automatic frame(input logic [7:0] q[$], input logic m, output logic [7:0] rx, output logic oe);
        i_host.start(m);
        foreach (q[i]) i_host.xfer(q[i], rx, oe);
        i_host.stop();
    endtask : frame
    task automatic status_is(input logic [7:0] exp, input logic m);
        logic [7:0] rx;
        logic       oe;
        frame({OPC_STATUS_READ, 8'h00}, m, rx, oe);
        check("status byte", {8'h0, rx}, {8'h0, exp});
        check("status oe", {15'h0, oe}, 16'h1);
        check("status port", {8'h0, status}, {8'h0, exp});
    endtask : status_is
    task automatic mwrite(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] rx;
        logic       oe;
        frame({OPC_LATCH_SET}, 1'b0, rx, oe);
        frame({OPC_MEM_WRITE, a[15:8], a[7:0], d}, 1'b0, rx, oe);
        wait_idle();
    endtask : mwrite
    // watchdog well past the expected run length
    initial begin
        repeat (90000) @(posedge clock);
        failures++;
        test_done();
    end
    initial begin
        logic [7:0]  rx;
        logic        oe;
        logic [15:0] lo;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        check("reset status", {8'h0, status}, 16'h0);
        check("reset oe", {15'h0, so_oe}, 16'h0);
        // host settles after reset before the first frame
        repeat (4) @(posedge clock);
        // command table, modes (0,0) and (1,1) in turn
        foreach (ROWS[r]) begin
            guard_n <= ROWS[r].guard_n;
            if (ROWS[r].two)
                frame({ROWS[r].op, ROWS[r].arg}, r[0], rx, oe);
            else
                frame({ROWS[r].op}, r[0], rx, oe);
            wait_idle();
            status_is(ROWS[r].exp, r[0]);
        end
        // page write into a stalled two-word buffer; third word refused
        wr_ready <= 1'b0;
        frame({OPC_LATCH_SET}, 1'b0, rx, oe);
        frame({OPC_MEM_WRITE, 8'h02, 8'hfe, 8'h5a, 8'ha5, 8'h77}, 1'b0, rx, oe);
        check("write valid", {15'h0, wr_valid}, 16'h1);
        check("write addr", {6'h0, wr_addr}, 16'h02fe);
        check("write data", {8'h0, wr_data}, 16'h005a);
        frame({OPC_LATCH_CLEAR}, 1'b1, rx, oe);
        status_is(8'h07, 1'b0);
        wr_ready <= 1'b1;
        wait_idle();
        status_is(8'h04, 1'b1);
        check("mem 2fe", {8'h0, mem[10'h2fe]}, 16'h005a);
        check("mem 2ff", {8'h0, mem[10'h2ff]}, 16'h00a5);
        check("mem 2e0", {8'h0, mem[10'h2e0]}, {8'h0, init_of(10'h2e0)});
        // read back in mode (1,1) with a pause between bytes
        i_host.start(1'b1);
        i_host.xfer(OPC_MEM_READ, rx, oe);
        i_host.xfer(8'h02, rx, oe);
        i_host.xfer(8'hfe, rx, oe);
        i_host.xfer(8'h00, rx, oe);
        check("read byte0", {8'h0, rx}, 16'h005a);
        i_host.pause(30, oe);
        check("oe in pause", {15'h0, oe}, 16'h0);
        i_host.xfer(8'h00, rx, oe);
        check("read byte1", {8'h0, rx}, 16'h00a5);
        i_host.stop();
        check("oe deselected", {15'h0, so_oe}, 16'h0);
        // guard settings: first guarded byte refused, byte below accepted except with setting 11
        for (int g = 1; g < 4; g++) begin
            lo = 16'h0400 - (16'h0080 << g);
            frame({OPC_LATCH_SET}, 1'b0, rx, oe);
            frame({OPC_STATUS_WRITE, 8'(g << 2)}, 1'b0, rx, oe);
            wait_idle();
            mwrite(lo - 16'h1, 8'h96);
            mwrite(lo, 8'h96);
            check("guard first", {8'h0, mem[lo[9:0]]}, {8'h0, init_of(lo[9:0])});
            lo = lo - 16'h1;
            if (g < 3)
                check("guard below", {8'h0, mem[lo[9:0]]}, 16'h0096);
            else
                check("guard full", {8'h0, mem[lo[9:0]]}, {8'h0, init_of(lo[9:0])});
        end
        // mid-run reset clears guard bits and latch
        check("status pre reset", {8'h0, status}, 16'h000e);
        rst_n <= 1'b0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        check("rerun status", {8'h0, status}, 16'h0);
        check("rerun oe", {15'h0, so_oe}, 16'h0);
        repeat (4) @(posedge clock);
        status_is(8'h00, 1'b1);
        test_done();
    end
endmodule : test_spi_eeprom_command_protect
`default_nettype wire
